// file: hdl/pmk_key_unlock.v
`include "pmk_map.vh"

// ----------------------------------------
// Two-write unlock tracker for mode register
// ----------------------------------------
module pmk_key_unlock (
	input wire core_clk_i,
	input wire rst_n_i,
	input wire any_wr_i,
	input wire key_wr_i,
	input wire mode_wr_i,
	input wire [`PMK_PKEY_W-1:0] key_data_i,
	output wire open_o
);

	localparam ST_LOCKED = 2'd0;
	localparam ST_HALF = 2'd1;
	localparam ST_OPEN = 2'd2;

	reg [1:0] state_q;
	reg [1:0] state_d;

	// Next state of the unlock sequence
	always @* begin
		state_d = state_q;
		if (key_wr_i) begin
			case (state_q)
				ST_HALF: begin
					// Second value completes the sequence
					if (key_data_i == `PMK_KEY_SECOND) begin
						state_d = ST_OPEN;
					end else if (key_data_i == `PMK_KEY_FIRST) begin
						state_d = ST_HALF;
					end else begin
						state_d = ST_LOCKED;
					end
				end
				default: begin
					// Always restart on the first value
					if (key_data_i == `PMK_KEY_FIRST) begin
						state_d = ST_HALF;
					end else begin
						state_d = ST_LOCKED;
					end
				end
			endcase
		end else if (mode_wr_i) begin
			// One mode write consumes the unlock
			state_d = ST_LOCKED;
		end else if (any_wr_i) begin
			// Stray write relocks
			state_d = ST_LOCKED;
		end
	end

	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ST_LOCKED;
		end else begin
			state_q <= state_d;
		end
	end

	assign open_o = (state_q == ST_OPEN);

endmodule

// file: hdl/pmk_power_ctrl.v
// Our own choice: the address-and-strobe port.
`include "pmk_map.vh"

module pmk_power_ctrl #(
	parameter SETTLE_CYC = `PMK_SETTLE_CYC
) (
	input wire core_clk_i,
	input wire rst_b_i,
	input wire [`PMK_AW-1:0] addr_i,
	input wire [`PMK_DW-1:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output wire [`PMK_DW-1:0] rdata_o,
	input wire seq_sleep_req_i,
	input wire timer_sleep_i,
	input wire wake_i,
	output wire core_pwr_en_o,
	output wire hs_clk_en_o,
	output wire sram_pwr_en_o,
	output wire sram_retain_o,
	output wire adc_switch_on_o,
	output wire hibernate_o,
	output wire pwr_unlocked_o,
	output wire lp_seq_access_en_o
);

	// ----------------------------------------
	// Power state codes
	// ----------------------------------------
	localparam ST_ACTIVE = 2'd0;
	localparam ST_ENTER = 2'd1;
	localparam ST_HIB = 2'd2;
	localparam ST_EXIT = 2'd3;
	localparam CW = 8;

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	reg rst_s1_q;
	reg rst_n_q;

	// Release is synchronous, assertion is not
	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// ----------------------------------------
	// Asynchronous inputs
	// ----------------------------------------
	wire [1:0] sync_lvl;
	wire timer_lvl;
	wire wake_lvl;
	reg timer_prev_q;
	reg wake_prev_q;

	// Timer and wake pin arrive from the slow clock
	pmk_sync #(
		.W(2)
	) u_sync (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_q),
		.async_i({wake_i, timer_sleep_i}),
		.level_o(sync_lvl)
	);

	assign timer_lvl = sync_lvl[0];
	assign wake_lvl = sync_lvl[1];

	// Edge memory on the filtered levels
	always @(posedge core_clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			timer_prev_q <= 1'b0;
			wake_prev_q <= 1'b0;
		end else begin
			timer_prev_q <= timer_lvl;
			wake_prev_q <= wake_lvl;
		end
	end

	wire timer_rise = timer_lvl & ~timer_prev_q;
	wire wake_rise = wake_lvl & ~wake_prev_q;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire hit_mode = (addr_i == `PMK_OFS_MODE);
	wire hit_pkey = (addr_i == `PMK_OFS_PKEY);
	wire hit_lkey = (addr_i == `PMK_OFS_LKEY);
	wire wr_mode = wr_i & hit_mode;
	wire wr_pkey = wr_i & hit_pkey;
	wire wr_lkey = wr_i & hit_lkey;

	// ----------------------------------------
	// Mode register protection
	// ----------------------------------------
	wire mode_open;

	// Any write outside the key and mode regs relocks
	pmk_key_unlock u_key (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_q),
		.any_wr_i(wr_i),
		.key_wr_i(wr_pkey),
		.mode_wr_i(wr_mode),
		.key_data_i(wdata_i[`PMK_PKEY_W-1:0]),
		.open_o(mode_open)
	);

	// Locked writes fall through with no effect
	wire mode_take = wr_mode & mode_open;

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	reg [`PMK_PKEY_W-1:0] pkey_q;
	reg [`PMK_LKEY_W-1:0] lkey_q;
	reg [1:0] mode_sel_q;
	reg ram_hold_enable_q;
	reg adc_switch_hold_q;
	reg sequencer_autosleep_en_q;
	reg timer_autosleep_en_q;

	// Key registers store whatever was written
	always @(posedge core_clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pkey_q <= `PMK_PKEY_RST;
			lkey_q <= `PMK_LKEY_RST;
		end else begin
			if (wr_pkey) begin
				pkey_q <= wdata_i[`PMK_PKEY_W-1:0];
			end
			// Low-power key field, guards only the sequencer permission
			if (wr_lkey) begin
				lkey_q <= wdata_i[`PMK_LKEY_W-1:0];
			end
		end
	end

	// Mode register fields, written only when unlocked
	always @(posedge core_clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mode_sel_q <= `PMK_MODE_RST;
			ram_hold_enable_q <= 1'b0;
			adc_switch_hold_q <= 1'b0;
			sequencer_autosleep_en_q <= 1'b0;
			timer_autosleep_en_q <= 1'b0;
		end else if (mode_take) begin
			// Field keeps the raw code, reserved ones too
			mode_sel_q <= wdata_i[`PMK_MODE_HI:`PMK_MODE_LO];
			ram_hold_enable_q <= wdata_i[`PMK_BIT_RAM];
			adc_switch_hold_q <= wdata_i[`PMK_BIT_ADC];
			sequencer_autosleep_en_q <= wdata_i[`PMK_BIT_SEQ];
			timer_autosleep_en_q <= wdata_i[`PMK_BIT_TMR];
		end
	end

	// ----------------------------------------
	// Low-power key decode
	// ----------------------------------------
	// Only the exact value opens, anything else locks
	wire lp_open = (lkey_q == `PMK_LKEY_OPEN);

	// ----------------------------------------
	// Sleep and wake requests
	// ----------------------------------------
	wire code_hib = (wdata_i[`PMK_MODE_HI:`PMK_MODE_LO] == `PMK_MODE_HIB);
	wire code_act = (wdata_i[`PMK_MODE_HI:`PMK_MODE_LO] == `PMK_MODE_ACTIVE);

	// Software entry by writing the hibernate code
	wire sw_sleep = mode_take & code_hib;
	// Software return to active mode
	wire sw_wake = mode_take & code_act;
	// Sequencer command honoured only when enabled
	wire seq_sleep = seq_sleep_req_i & sequencer_autosleep_en_q;
	// Timer event honoured only when enabled
	wire tmr_sleep = timer_rise & timer_autosleep_en_q;

	// Reserved codes raise neither request
	wire sleep_req = sw_sleep | seq_sleep | tmr_sleep;
	wire wake_req = sw_wake | wake_rise;

	// ----------------------------------------
	// Power sequencing
	// ----------------------------------------
	reg [1:0] pst_q;
	reg [1:0] pst_d;
	reg [CW-1:0] cnt_q;
	reg [CW-1:0] cnt_d;
	wire cnt_done = (cnt_q == {CW{1'b0}});
	wire [CW-1:0] settle_ld = SETTLE_CYC[CW-1:0];

	// Clock stops before power drops, and power
	// returns before the clock, so no logic sees
	// a clock on an unpowered core
	always @* begin
		pst_d = pst_q;
		cnt_d = cnt_q;
		case (pst_q)
			ST_ACTIVE: begin
				if (sleep_req) begin
					pst_d = ST_ENTER;
					cnt_d = settle_ld;
				end
			end
			ST_ENTER: begin
				if (cnt_done) begin
					pst_d = ST_HIB;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			ST_HIB: begin
				if (wake_req) begin
					pst_d = ST_EXIT;
					cnt_d = settle_ld;
				end
			end
			ST_EXIT: begin
				if (cnt_done) begin
					pst_d = ST_ACTIVE;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			default: begin
				pst_d = ST_ACTIVE;
				cnt_d = {CW{1'b0}};
			end
		endcase
	end

	always @(posedge core_clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pst_q <= ST_ACTIVE;
			cnt_q <= {CW{1'b0}};
		end else begin
			pst_q <= pst_d;
			cnt_q <= cnt_d;
		end
	end

	// ----------------------------------------
	// Power control outputs
	// ----------------------------------------
	reg core_pwr_q;
	reg hs_clk_q;
	reg sram_pwr_q;
	reg sram_ret_q;
	reg adc_sw_q;
	reg hib_q;

	// Outputs follow the next state so they line up with it
	always @(posedge core_clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			core_pwr_q <= 1'b1;
			hs_clk_q <= 1'b1;
			sram_pwr_q <= 1'b1;
			sram_ret_q <= 1'b0;
			adc_sw_q <= 1'b1;
			hib_q <= 1'b0;
		end else begin
			// Everything up in active mode
			hs_clk_q <= (pst_d == ST_ACTIVE);
			core_pwr_q <= (pst_d != ST_HIB);
			// SRAM down in hibernate
			sram_pwr_q <= (pst_d != ST_HIB);
			// Retention is meaningful only while SRAM is down
			sram_ret_q <= (pst_d == ST_HIB) & ram_hold_enable_q;
			// Switch off in hibernate unless held
			adc_sw_q <= (pst_d != ST_HIB) | adc_switch_hold_q;
			hib_q <= (pst_d == ST_HIB);
		end
	end

	assign core_pwr_en_o = core_pwr_q;
	assign hs_clk_en_o = hs_clk_q;
	assign sram_pwr_en_o = sram_pwr_q;
	assign sram_retain_o = sram_ret_q;
	assign adc_switch_on_o = adc_sw_q;
	assign hibernate_o = hib_q;
	assign pwr_unlocked_o = mode_open;

	// ----------------------------------------
	// Sequencer permission output
	// ----------------------------------------
	reg lp_acc_q;

	// Registered to keep the permission glitch free
	always @(posedge core_clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			lp_acc_q <= 1'b0;
		end else begin
			lp_acc_q <= lp_open;
		end
	end

	assign lp_seq_access_en_o = lp_acc_q;

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	reg [`PMK_DW-1:0] rdata_q;
	reg [`PMK_DW-1:0] rd_mux;

	// Reserved bits and unmapped addresses read zero
	always @* begin
		rd_mux = {`PMK_DW{1'b0}};
		if (hit_mode) begin
			rd_mux[`PMK_BIT_RAM] = ram_hold_enable_q;
			rd_mux[`PMK_BIT_ADC] = adc_switch_hold_q;
			rd_mux[`PMK_BIT_SEQ] = sequencer_autosleep_en_q;
			rd_mux[`PMK_BIT_TMR] = timer_autosleep_en_q;
			// Last written code, not the live state
			rd_mux[`PMK_MODE_HI:`PMK_MODE_LO] = mode_sel_q;
		end else if (hit_pkey) begin
			rd_mux[`PMK_PKEY_W-1:0] = pkey_q;
		end else if (hit_lkey) begin
			rd_mux[`PMK_LKEY_W-1:0] = lkey_q;
		end
	end

	// Data stand only in the cycle after the strobe
	always @(posedge core_clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rdata_q <= {`PMK_DW{1'b0}};
		end else if (rd_i) begin
			rdata_q <= rd_mux;
		end else begin
			rdata_q <= {`PMK_DW{1'b0}};
		end
	end

	assign rdata_o = rdata_q;

endmodule

// file: hdl/pmk_sync.v
// ----------------------------------------
// Three-stage input synchroniser
// ----------------------------------------
module pmk_sync #(
	parameter W = 2
) (
	input wire core_clk_i,
	input wire rst_n_i,
	input wire [W-1:0] async_i,
	output wire [W-1:0] level_o
);

	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : bit_sync
			reg s1_q;
			reg s2_q;
			reg s3_q;
			reg lvl_q;
			// Stage one feeds stage two only
			always @(posedge core_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
					lvl_q <= 1'b0;
				end else begin
					s1_q <= async_i[g];
					s2_q <= s1_q;
					s3_q <= s2_q;
					// Change counts once two stages agree
					if (s2_q == s3_q) begin
						lvl_q <= s3_q;
					end
				end
			end
			assign level_o[g] = lvl_q;
		end
	endgenerate

endmodule

// file: include/pmk_map.vh
`ifndef PMK_MAP_VH
`define PMK_MAP_VH

// ----------------------------------------
// Bus geometry
// ----------------------------------------
`define PMK_AW 16
`define PMK_DW 32

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define PMK_OFS_MODE 16'h0a00
`define PMK_OFS_PKEY 16'h0a04
`define PMK_OFS_LKEY 16'h210c

// ----------------------------------------
// Unlock values and reset values
// ----------------------------------------
`define PMK_KEY_FIRST 16'h4859
`define PMK_KEY_SECOND 16'hf27b
`define PMK_PKEY_W 16
`define PMK_PKEY_RST 16'h0000
`define PMK_LKEY_W 20
`define PMK_LKEY_OPEN 20'hc59d6
`define PMK_LKEY_RST 20'h00000

// ----------------------------------------
// Power mode register fields
// ----------------------------------------
`define PMK_BIT_RAM 15
`define PMK_BIT_ADC 14
`define PMK_BIT_SEQ 3
`define PMK_BIT_TMR 2
`define PMK_MODE_HI 1
`define PMK_MODE_LO 0
`define PMK_MODE_ACTIVE 2'h1
`define PMK_MODE_HIB 2'h2
`define PMK_MODE_RST 2'h1

// ----------------------------------------
// Timing
// ----------------------------------------
`define PMK_SETTLE_CYC 2

`endif

// file: verification/pmk_power_ctrl_checker.sv
`include "pmk_map.vh"

module pmk_power_ctrl_checker #(
	parameter int SETTLE_CYC = 2
) (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic [`PMK_AW-1:0] addr_i,
	input wire logic [`PMK_DW-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic seq_sleep_req_i,
	input wire logic core_pwr_en_o,
	input wire logic hs_clk_en_o,
	input wire logic sram_pwr_en_o,
	input wire logic sram_retain_o,
	input wire logic adc_switch_on_o,
	input wire logic hibernate_o,
	input wire logic pwr_unlocked_o,
	input wire logic lp_seq_access_en_o
);
	timeunit 1ns;
	timeprecision 100ps;

	localparam int ENT = SETTLE_CYC + 1;
	wire mode_wr = wr_i && addr_i == `PMK_OFS_MODE;
	wire key_wr = wr_i && addr_i == `PMK_OFS_PKEY;
	wire lk_open = wdata_i[19:0] == `PMK_LKEY_OPEN;
	reg [2:0] fld_q;

	// Shadow of accepted hold bits and sequencer autosleep bit; locked writes never reach it
	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			fld_q <= 3'h0;
		else if (mode_wr && pwr_unlocked_o)
			fld_q <= {wdata_i[15:14], wdata_i[3]};
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);

	unlock_pair_a: assert property (
		key_wr && wdata_i[15:0] == `PMK_KEY_SECOND
		&& $past(key_wr && wdata_i[15:0] == `PMK_KEY_FIRST) |=> pwr_unlocked_o)
		else $error("key pair did not unlock");
	relock_a: assert property (
		wr_i && addr_i != `PMK_OFS_PKEY |=> !pwr_unlocked_o)
		else $error("unlock survived another write");
	locked_mode_a: assert property (
		mode_wr && !pwr_unlocked_o && hs_clk_en_o && !hibernate_o && !seq_sleep_req_i
		|=> hs_clk_en_o) else $error("locked mode write took effect");
	enter_hib_a: assert property (
		mode_wr && pwr_unlocked_o && wdata_i[1:0] == `PMK_MODE_HIB && hs_clk_en_o
		&& !hibernate_o |=> !hs_clk_en_o ##ENT hibernate_o && !core_pwr_en_o && !sram_pwr_en_o)
		else $error("hibernate entry wrong");
	// Outputs are built from the stored bits, so they trail a field write by one cycle
	hib_hold_a: assert property (
		hibernate_o |-> adc_switch_on_o == $past(fld_q[1]) && sram_retain_o == $past(fld_q[2]))
		else $error("hibernate hold outputs wrong");
	active_pwr_a: assert property (
		!hibernate_o |-> core_pwr_en_o && sram_pwr_en_o && adc_switch_on_o && !sram_retain_o)
		else $error("active power outputs wrong");
	seq_sleep_a: assert property (
		seq_sleep_req_i && hs_clk_en_o && !hibernate_o && !mode_wr |=> hs_clk_en_o != fld_q[0])
		else $error("sequencer sleep gating wrong");
	lp_key_a: assert property (
		wr_i && addr_i == `PMK_OFS_LKEY |-> ##2 lp_seq_access_en_o == $past(lk_open, 2))
		else $error("low power access wrong");

	cover property (mode_wr && pwr_unlocked_o);
	cover property ($rose(hibernate_o) && sram_retain_o);
	cover property ($rose(lp_seq_access_en_o));
endmodule

bind pmk_power_ctrl pmk_power_ctrl_checker #(.SETTLE_CYC(SETTLE_CYC)) u_chk (
	.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .seq_sleep_req_i(seq_sleep_req_i), .core_pwr_en_o(core_pwr_en_o),
	.hs_clk_en_o(hs_clk_en_o), .sram_pwr_en_o(sram_pwr_en_o), .sram_retain_o(sram_retain_o),
	.adc_switch_on_o(adc_switch_on_o), .hibernate_o(hibernate_o),
	.pwr_unlocked_o(pwr_unlocked_o), .lp_seq_access_en_o(lp_seq_access_en_o)
);

// file: verification/test_power_mode_key_control.sv
`include "pmk_map.vh"

module test_power_mode_key_control;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int S = 1;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic seq = 1'b0;
	logic tmr = 1'b0;
	logic wake = 1'b0;
	logic [31:0] rdata;
	logic core_en, hs_en, sram_en, retain, adc_on, hib, unl, lp_en;
	int fail_count = 0;
	int n_checks = 0;

	always #5 clk = ~clk;

	pmk_power_ctrl #(.SETTLE_CYC(S)) u_dut (
		.core_clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata), .seq_sleep_req_i(seq), .timer_sleep_i(tmr),
		.wake_i(wake), .core_pwr_en_o(core_en), .hs_clk_en_o(hs_en), .sram_pwr_en_o(sram_en),
		.sram_retain_o(retain), .adc_switch_on_o(adc_on), .hibernate_o(hib),
		.pwr_unlocked_o(unl), .lp_seq_access_en_o(lp_en)
	);

	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic end_sim;
		$display("checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Strobe stays high on return so writes may follow back to back
	task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		rd <= 1'b0;
		@(posedge clk);
	endtask

	task automatic idle(input int n);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (n) @(posedge clk);
	endtask

	// Read data only stands in the cycle after the strobe
	task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
		addr <= a;
		rd <= 1'b1;
		wr <= 1'b0;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, exp);
		@(posedge clk);
	endtask

	task automatic unlock;
		wr_reg(`PMK_OFS_PKEY, 32'h4859);
		wr_reg(`PMK_OFS_PKEY, 32'hf27b);
	endtask

	task automatic set_mode(input logic [31:0] d);
		unlock;
		wr_reg(`PMK_OFS_MODE, d);
		idle(S + 4);
	endtask

	task automatic pwr(input logic [5:0] e);
		@(negedge clk);
		chk({core_en, hs_en, sram_en, retain, adc_on, hib}, e);
		@(posedge clk);
	endtask

	// Bounded wait; a hang ends the run at once
	task automatic wait_hib(input logic v);
		int i;
		idle(0);
		for (i = 0; i < 40 && hib !== v; i++)
			@(negedge clk);
		chk(hib, v);
		if (hib !== v)
			end_sim;
		@(posedge clk);
	endtask

	// 0 sequencer, 1 timer, 2 wake pin; async ones held two cycles for the sync
	task automatic pulse(input int j);
		seq <= (j == 0);
		tmr <= (j == 1);
		wake <= (j == 2);
		@(posedge clk);
		seq <= 1'b0;
		@(posedge clk);
		tmr <= 1'b0;
		wake <= 1'b0;
		@(posedge clk);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		idle(4);
		rd_chk(`PMK_OFS_MODE, 32'h1);
		rd_chk(`PMK_OFS_PKEY, 32'h0);
		rd_chk(`PMK_OFS_LKEY, 32'h0);
		rd_chk(16'h0a08, 32'h0);
		pwr(6'h3a);
		$display("test reset done");
		// Locked write, then a key pair broken by another write
		wr_reg(`PMK_OFS_MODE, 32'h2);
		wr_reg(`PMK_OFS_PKEY, 32'h4859);
		wr_reg(`PMK_OFS_LKEY, 32'h0);
		wr_reg(`PMK_OFS_PKEY, 32'hf27b);
		wr_reg(`PMK_OFS_MODE, 32'h2);
		idle(S + 4);
		rd_chk(`PMK_OFS_MODE, 32'h1);
		pwr(6'h3a);
		$display("test lock done");
		for (int c = 0; c < 4; c += 3) begin
			set_mode(c);
			rd_chk(`PMK_OFS_MODE, c);
			pwr(6'h3a);
		end
		$display("test reserved done");
		// Hibernate without and with hold bits; wake by pin, then by write
		for (int k = 0; k < 2; k++) begin
			unlock;
			idle(0);
			@(negedge clk) chk(unl, 1);
			@(posedge clk);
			wr_reg(`PMK_OFS_MODE, k ? 32'hc002 : 32'h2);
			wait_hib(1);
			pwr(k ? 6'h07 : 6'h01);
			if (k)
				set_mode(1);
			else
				pulse(2);
			wait_hib(0);
			idle(S + 4);
			pwr(6'h3a);
			rd_chk(`PMK_OFS_MODE, k ? 32'h1 : 32'h2);
		end
		$display("test hibernate done");
		// Autosleep ignored while disabled, taken when enabled
		for (int j = 0; j < 2; j++) begin
			set_mode(1);
			pulse(j);
			idle(10);
			pwr(6'h3a);
			set_mode(j ? 32'h5 : 32'h9);
			pulse(j);
			wait_hib(1);
			pulse(2);
			wait_hib(0);
			rd_chk(`PMK_OFS_MODE, j ? 32'h5 : 32'h9);
		end
		$display("test autosleep done");
		wr_reg(`PMK_OFS_LKEY, 32'hfffc59d6);
		idle(2);
		@(negedge clk) chk(lp_en, 1);
		@(posedge clk);
		rd_chk(`PMK_OFS_LKEY, 32'h000c59d6);
		for (int v = 0; v < 2; v++) begin
			wr_reg(`PMK_OFS_LKEY, 32'hc59d6);
			wr_reg(`PMK_OFS_LKEY, v ? 32'hc59d7 : 32'h0);
			idle(2);
			@(negedge clk) chk(lp_en, 0);
			@(posedge clk);
		end
		$display("test low power key done");
		end_sim;
	end
endmodule
